// ===== hdl/rlpm_top.sv
`include "rlpm_consts.svh"
// Operation
// - sleep on falling sleep control, or at power-up with it low
// - asleep, all terminations high impedance and all operation stopped
// - sleep entry completes within 2 us of the fall
// - sleep control high leaves sleep for receiver detect within 100 us
// - link break or no partner found sends device to receiver detect
// - in receiver detect, input terminations high impedance, core mostly off
// - reconnected partner returns device to normal without control change
// - timer notices U2/U3 idle and switches off selected circuitry
// - LFPS activity in U2/U3 returns device to active mode
// - detect cycle sets receive termination high-Z before probing transmitters
// - both channels found switches terminations to low impedance
// - failed channel gets transmitter high-Z and low-power state
// - failed detect retries every 12 ms until found or sleep
// - compliance only with sleep control and compliance select high
// - compliance keeps low-Z receive termination, auto detect disabled
// - input below idle threshold asserts electrical idle on its transmitter
// - input above exit threshold resumes passing signal to output
// - electrical idle entry and exit take at most one cycle
// - conditioning set by six three-level inputs: low, high, unconnected
// - de-emphasis per channel from its de-emphasis and swing selects
module rlpm_top #(
	parameter int RETRY_CYC = `RLPM_RETRY_CYC
) (
	// clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic SYS_RST_IN,
	// static control pins
	input wire logic SLEEP_CTRL_IN,
	input wire logic COMPLIANCE_SELECT_IN,
	input wire rlpm_pkg::rlpm_pins_t SETTING_PINS_IN,
	// analog sense, per channel
	input wire logic [1:0] RX_TERM_SENSE_IN,
	input wire logic [1:0] RX_SIGNAL_IN,
	input wire logic LINK_BREAK_IN,
	// analog control, per channel
	output logic [1:0] RX_TERM_LOWZ_OUT,
	output logic [1:0] TX_TERM_LOWZ_OUT,
	output logic [1:0] TX_ENABLE_OUT,
	output logic [1:0] TX_EIDLE_OUT,
	output logic [1:0] CH_LOWPOWER_OUT,
	output logic RX_DETECT_PROBE_OUT,
	output logic CORE_ON_OUT,
	output rlpm_pkg::rlpm_state_t MODE_OUT,
	output rlpm_pkg::rlpm_cond_t COND_OUT,
	// avalon-mm slave
	input wire logic [3:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT
);
	import rlpm_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// three-level pin to two-bit code
	function automatic logic [1:0] tri_decode(input rlpm_tri_t p);
		logic [1:0] c;
		c = `RLPM_TRI_MID;
		if (p.hi && !p.lo)
			c = `RLPM_TRI_HIGH;
		else if (p.lo && !p.hi)
			c = `RLPM_TRI_LOW;
		return c;
	endfunction

	localparam logic [`RLPM_TMR_W-1:0] SETTLE_LAST =
		`RLPM_TMR_W'(`RLPM_SETTLE_CYC - 1);
	localparam logic [`RLPM_TMR_W-1:0] PROBE_LAST =
		`RLPM_TMR_W'(`RLPM_PROBE_CYC - 1);
	localparam logic [`RLPM_TMR_W-1:0] U2_LAST =
		`RLPM_TMR_W'(`RLPM_U2_IDLE_CYC - 1);
	localparam logic [`RLPM_TMR_W-1:0] RETRY_LAST =
		`RLPM_TMR_W'(RETRY_CYC - 1);

	rlpm_state_t state_ff, nxt_state;
	logic [`RLPM_TMR_W-1:0] timer_ff, nxt_timer;
	logic en_prev_ff;
	logic [1:0] found_ff;
	logic [31:0] ctrl_ff;
	logic wait_ff;
	logic sleep_go, comp_go, autolp;

	// ------------------------------------------------------------
	// mode priority
	// ------------------------------------------------------------
	// falling sleep control, or sleep control low in any mode
	assign sleep_go = (en_prev_ff && !SLEEP_CTRL_IN) ||
		!SLEEP_CTRL_IN;
	assign comp_go = SLEEP_CTRL_IN && COMPLIANCE_SELECT_IN;
	assign autolp = ctrl_ff[`RLPM_CTRL_AUTOLP_BIT];

	// sleep control history for edge detection
	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			en_prev_ff <= 1'b0;
		else
			en_prev_ff <= SLEEP_CTRL_IN;
	end

	// ------------------------------------------------------------
	// mode sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		nxt_timer = `RLPM_TMR_W'(timer_ff + 1'b1);
		if (sleep_go)
			nxt_state = RLPM_SLEEP;
		else if (comp_go)
			nxt_state = RLPM_COMPLY;
		else
		begin
			case (state_ff)
				RLPM_SLEEP:
					nxt_state = RLPM_SETTLE;
				RLPM_COMPLY:
					nxt_state = RLPM_SETTLE;
				RLPM_SETTLE:
					if (timer_ff == SETTLE_LAST)
						nxt_state = RLPM_PROBE;
				RLPM_PROBE:
					if (timer_ff == PROBE_LAST)
					begin
						if (RX_TERM_SENSE_IN == 2'h3)
							nxt_state = RLPM_NORMAL;
						else
							nxt_state = RLPM_RETRY;
					end
				RLPM_RETRY:
					if (timer_ff == RETRY_LAST)
						nxt_state = RLPM_SETTLE;
				RLPM_NORMAL:
				begin
					if (LINK_BREAK_IN)
						nxt_state = RLPM_SETTLE;
					else if (RX_SIGNAL_IN != 2'h0)
						nxt_timer = '0;
					else if (timer_ff == U2_LAST)
					begin
						// hold the count while auto low power is off
						nxt_timer = timer_ff;
						if (autolp)
							nxt_state = RLPM_LOWPWR;
					end
				end
				RLPM_LOWPWR:
					if (LINK_BREAK_IN)
						nxt_state = RLPM_SETTLE;
					else if (RX_SIGNAL_IN != 2'h0)
						nxt_state = RLPM_NORMAL;
				default:
					nxt_state = RLPM_SLEEP;
			endcase
		end
		if (nxt_state != state_ff)
			nxt_timer = '0;
	end

	// state and shared timer
	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
		begin
			state_ff <= RLPM_SLEEP;
			timer_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
			timer_ff <= nxt_timer;
		end
	end

	// per-channel detect result, kept for the retry wait
	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			found_ff <= 2'h0;
		else if (state_ff == RLPM_PROBE && timer_ff == PROBE_LAST)
			found_ff <= RX_TERM_SENSE_IN;
	end

	// ------------------------------------------------------------
	// analog controls, registered from the next mode
	// ------------------------------------------------------------
	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
		begin
			RX_TERM_LOWZ_OUT <= 2'h0;
			TX_TERM_LOWZ_OUT <= 2'h0;
			TX_ENABLE_OUT <= 2'h0;
			TX_EIDLE_OUT <= 2'h3;
			CH_LOWPOWER_OUT <= 2'h3;
			RX_DETECT_PROBE_OUT <= 1'b0;
			CORE_ON_OUT <= 1'b0;
			MODE_OUT <= RLPM_SLEEP;
		end
		else
		begin
			MODE_OUT <= nxt_state;
			RX_DETECT_PROBE_OUT <= (nxt_state == RLPM_PROBE);
			case (nxt_state)
				RLPM_NORMAL, RLPM_COMPLY:
				begin
					RX_TERM_LOWZ_OUT <= 2'h3;
					TX_TERM_LOWZ_OUT <= 2'h3;
					TX_ENABLE_OUT <= 2'h3;
					TX_EIDLE_OUT <= ~RX_SIGNAL_IN;
					CH_LOWPOWER_OUT <= 2'h0;
					CORE_ON_OUT <= 1'b1;
				end
				RLPM_LOWPWR:
				begin
					RX_TERM_LOWZ_OUT <= 2'h3;
					TX_TERM_LOWZ_OUT <= 2'h3;
					TX_ENABLE_OUT <= 2'h3;
					TX_EIDLE_OUT <= 2'h3;
					CH_LOWPOWER_OUT <= 2'h3;
					CORE_ON_OUT <= 1'b0;
				end
				RLPM_RETRY:
				begin
					RX_TERM_LOWZ_OUT <= 2'h0;
					TX_TERM_LOWZ_OUT <= 2'h0;
					TX_ENABLE_OUT <= 2'h0;
					TX_EIDLE_OUT <= 2'h3;
					CH_LOWPOWER_OUT <= ~((state_ff == RLPM_PROBE) ?
						RX_TERM_SENSE_IN : found_ff);
					CORE_ON_OUT <= 1'b0;
				end
				default:
				begin
					// sleep and detect: everything high impedance
					RX_TERM_LOWZ_OUT <= 2'h0;
					TX_TERM_LOWZ_OUT <= 2'h0;
					TX_ENABLE_OUT <= 2'h0;
					TX_EIDLE_OUT <= 2'h3;
					CH_LOWPOWER_OUT <= 2'h3;
					CORE_ON_OUT <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// conditioning decode
	// ------------------------------------------------------------
	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			COND_OUT <= {8{`RLPM_TRI_MID}};
		else
		begin
			COND_OUT.eq_ch1 <= tri_decode(SETTING_PINS_IN.eq_ch1);
			COND_OUT.eq_ch2 <= tri_decode(SETTING_PINS_IN.eq_ch2);
			COND_OUT.os_ch1 <= tri_decode(SETTING_PINS_IN.os_ch1);
			COND_OUT.os_ch2 <= tri_decode(SETTING_PINS_IN.os_ch2);
			COND_OUT.deos_ch1 <= {tri_decode(SETTING_PINS_IN.de_ch1),
				tri_decode(SETTING_PINS_IN.os_ch1)};
			COND_OUT.deos_ch2 <= {tri_decode(SETTING_PINS_IN.de_ch2),
				tri_decode(SETTING_PINS_IN.os_ch2)};
		end
	end

	// ------------------------------------------------------------
	// avalon-mm slave: one wait cycle per access
	// ------------------------------------------------------------
	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			wait_ff <= 1'b1;
		else
			wait_ff <= !((AVS_READ_IN || AVS_WRITE_IN) && wait_ff);
	end
	assign AVS_WAITREQUEST_OUT = wait_ff;

	// control register, written at the completing edge
	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			ctrl_ff <= `RLPM_CTRL_RST;
		else if (AVS_WRITE_IN && !wait_ff &&
			AVS_ADDRESS_IN == `RLPM_CTRL_OFS)
			ctrl_ff <= {31'h0, AVS_WRITEDATA_IN[`RLPM_CTRL_AUTOLP_BIT]};
	end

	// read data, latched in the wait cycle
	always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN)
	begin
		if (SYS_RST_IN)
			AVS_READDATA_OUT <= 32'h0;
		else if (AVS_READ_IN && wait_ff)
		begin
			case (AVS_ADDRESS_IN)
				`RLPM_CTRL_OFS:
					AVS_READDATA_OUT <= ctrl_ff;
				`RLPM_STATUS_OFS:
					AVS_READDATA_OUT <= {22'h0, found_ff, TX_EIDLE_OUT,
						CH_LOWPOWER_OUT, CORE_ON_OUT, MODE_OUT};
				`RLPM_COND_OFS:
					AVS_READDATA_OUT <= {16'h0, COND_OUT};
				default:
					AVS_READDATA_OUT <= 32'h0; // unmapped
			endcase
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sleep_entry_a: assert property (@(posedge CORE_CLK_IN)
		disable iff (SYS_RST_IN)
		$fell(SLEEP_CTRL_IN) |-> ##[0:2] (MODE_OUT == RLPM_SLEEP))
		else $error("sleep not entered after control fell");

	sleep_hiz_a: assert property (@(posedge CORE_CLK_IN)
		disable iff (SYS_RST_IN)
		MODE_OUT == RLPM_SLEEP |-> RX_TERM_LOWZ_OUT == 2'h0 &&
			TX_TERM_LOWZ_OUT == 2'h0 && TX_ENABLE_OUT == 2'h0 &&
			!CORE_ON_OUT)
		else $error("terminations not high impedance in sleep");

	sleep_time_a: assert property (@(posedge CORE_CLK_IN)
		disable iff (SYS_RST_IN)
		$fell(SLEEP_CTRL_IN) |=> ##[0:19] (RX_TERM_LOWZ_OUT == 2'h0 &&
			TX_ENABLE_OUT == 2'h0))
		else $error("sleep entry exceeded 2 us");

	wake_a: assert property (@(posedge CORE_CLK_IN)
		disable iff (SYS_RST_IN)
		state_ff == RLPM_SLEEP && SLEEP_CTRL_IN && !COMPLIANCE_SELECT_IN
			|=> state_ff == RLPM_SETTLE)
		else $error("sleep exit to detect missed");

	break_a: assert property (@(posedge CORE_CLK_IN)
		disable iff (SYS_RST_IN)
		state_ff == RLPM_NORMAL && LINK_BREAK_IN && SLEEP_CTRL_IN &&
			!COMPLIANCE_SELECT_IN |=> state_ff == RLPM_SETTLE)
		else $error("link break did not start detect");

	detect_hiz_a: assert property (@(posedge CORE_CLK_IN)
		disable iff (SYS_RST_IN)
		RX_DETECT_PROBE_OUT |-> RX_TERM_LOWZ_OUT == 2'h0 &&
			$past(RX_TERM_LOWZ_OUT) == 2'h0 && !CORE_ON_OUT)
		else $error("probe while receive termination low impedance");

	found_a: assert property (@(posedge CORE_CLK_IN)
		disable iff (SYS_RST_IN)
		state_ff == RLPM_PROBE && timer_ff == PROBE_LAST &&
			RX_TERM_SENSE_IN == 2'h3 && !sleep_go && !comp_go
			|=> RX_TERM_LOWZ_OUT == 2'h3 && TX_TERM_LOWZ_OUT == 2'h3)
		else $error("terminations not switched after detect");

	fail_a: assert property (@(posedge CORE_CLK_IN)
		disable iff (SYS_RST_IN)
		state_ff == RLPM_PROBE && timer_ff == PROBE_LAST &&
			RX_TERM_SENSE_IN != 2'h3 && !sleep_go && !comp_go
			|=> TX_ENABLE_OUT == 2'h0 &&
			CH_LOWPOWER_OUT == ~$past(RX_TERM_SENSE_IN))
		else $error("failed channel not parked");

	retry_a: assert property (@(posedge CORE_CLK_IN)
		disable iff (SYS_RST_IN)
		state_ff == RLPM_RETRY && timer_ff == RETRY_LAST &&
			!sleep_go && !comp_go |=> state_ff == RLPM_SETTLE)
		else $error("detect retry not started on time");

	comply_a: assert property (@(posedge CORE_CLK_IN)
		disable iff (SYS_RST_IN)
		SLEEP_CTRL_IN && COMPLIANCE_SELECT_IN |=>
			MODE_OUT == RLPM_COMPLY && RX_TERM_LOWZ_OUT == 2'h3 &&
			!RX_DETECT_PROBE_OUT)
		else $error("compliance mode not held");

	u2_entry_a: assert property (@(posedge CORE_CLK_IN)
		disable iff (SYS_RST_IN)
		state_ff == RLPM_NORMAL && timer_ff == U2_LAST && autolp &&
			RX_SIGNAL_IN == 2'h0 && !LINK_BREAK_IN && !sleep_go &&
			!comp_go |=> CH_LOWPOWER_OUT == 2'h3)
		else $error("idle link not put in low power");

	lfps_wake_a: assert property (@(posedge CORE_CLK_IN)
		disable iff (SYS_RST_IN)
		state_ff == RLPM_LOWPWR && RX_SIGNAL_IN != 2'h0 &&
			!LINK_BREAK_IN && !sleep_go && !comp_go
			|=> MODE_OUT == RLPM_NORMAL && CORE_ON_OUT)
		else $error("activity did not wake low power");

	eidle_a: assert property (@(posedge CORE_CLK_IN)
		disable iff (SYS_RST_IN)
		MODE_OUT == RLPM_NORMAL |-> TX_EIDLE_OUT == ~$past(RX_SIGNAL_IN))
		else $error("electrical idle not tracking input");

	cond_a: assert property (@(posedge CORE_CLK_IN)
		disable iff (SYS_RST_IN)
		$stable(SETTING_PINS_IN) |=> COND_OUT.deos_ch1 ==
			{tri_decode($past(SETTING_PINS_IN.de_ch1)),
			tri_decode($past(SETTING_PINS_IN.os_ch1))})
		else $error("de-emphasis setting mis-decoded");

endmodule // rlpm_top

// ===== hdl/rlpm_consts.svh
`ifndef RLPM_CONSTS_SVH
`define RLPM_CONSTS_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define RLPM_CLK_KHZ 10000
// sleep entry, longest time (round down)
`define RLPM_SLEEP_ENTRY_NS 2000
`define RLPM_SLEEP_ENTRY_CYC ((`RLPM_SLEEP_ENTRY_NS * `RLPM_CLK_KHZ) / 1000000)
// sleep exit to detect, longest time (round down)
`define RLPM_WAKE_NS 100000
`define RLPM_WAKE_CYC ((`RLPM_WAKE_NS * `RLPM_CLK_KHZ) / 1000000)
// receiver detect retry interval
`define RLPM_RETRY_MS 12
`define RLPM_RETRY_CYC (`RLPM_RETRY_MS * `RLPM_CLK_KHZ)
// receive termination settle before probing, least time (round up)
`define RLPM_SETTLE_NS 1000
`define RLPM_SETTLE_CYC ((`RLPM_SETTLE_NS * `RLPM_CLK_KHZ + 999999) / 1000000)
// far-end termination probe window, least time (round up)
`define RLPM_PROBE_NS 2000
`define RLPM_PROBE_CYC ((`RLPM_PROBE_NS * `RLPM_CLK_KHZ + 999999) / 1000000)
// idle time on both channels before low-power entry
`define RLPM_U2_IDLE_NS 300000
`define RLPM_U2_IDLE_CYC (((`RLPM_U2_IDLE_NS / 1000) * `RLPM_CLK_KHZ) / 1000)
// electrical idle entry/exit, longest time, never under one cycle
`define RLPM_EIDLE_NS 6
`define RLPM_EIDLE_RAW ((`RLPM_EIDLE_NS * `RLPM_CLK_KHZ) / 1000000)
`define RLPM_EIDLE_CYC ((`RLPM_EIDLE_RAW > 0) ? `RLPM_EIDLE_RAW : 1)
`define RLPM_TMR_W 17

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define RLPM_CTRL_OFS 4'h0
`define RLPM_STATUS_OFS 4'h4
`define RLPM_COND_OFS 4'h8
`define RLPM_CTRL_RST 32'h0000_0001
`define RLPM_CTRL_AUTOLP_BIT 0

// ----------------------------------------------------------------
// three-level codes
// ----------------------------------------------------------------
`define RLPM_TRI_LOW 2'h0
`define RLPM_TRI_MID 2'h1
`define RLPM_TRI_HIGH 2'h2

`endif

// ===== hdl/rlpm_pkg.sv
package rlpm_pkg;

	// ------------------------------------------------------------
	// pin sense of a three-level control input
	// ------------------------------------------------------------
	typedef struct packed {
		logic hi; // pin seen high
		logic lo; // pin seen low; neither means unconnected
	} rlpm_tri_t;

	typedef struct packed {
		rlpm_tri_t eq_ch2;
		rlpm_tri_t eq_ch1;
		rlpm_tri_t de_ch2;
		rlpm_tri_t de_ch1;
		rlpm_tri_t os_ch2;
		rlpm_tri_t os_ch1;
	} rlpm_pins_t;

	// decoded per-channel conditioning settings
	typedef struct packed {
		logic [1:0] eq_ch2;
		logic [1:0] eq_ch1;
		logic [3:0] deos_ch2; // {de, os} pair for de-emphasis
		logic [3:0] deos_ch1;
		logic [1:0] os_ch2;
		logic [1:0] os_ch1;
	} rlpm_cond_t;

	// ------------------------------------------------------------
	// operating modes, gray along sleep-detect-normal-lowpower
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		RLPM_SLEEP = 3'h0,
		RLPM_SETTLE = 3'h1,
		RLPM_PROBE = 3'h3,
		RLPM_NORMAL = 3'h2,
		RLPM_LOWPWR = 3'h6,
		RLPM_RETRY = 3'h7,
		RLPM_COMPLY = 3'h5
	} rlpm_state_t;

endpackage

// ===== dv/rlpm_link_partner.sv
module rlpm_link_partner (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// bench commands
	input wire logic [1:0] present_in,
	input wire logic [1:0] active_in,
	input wire logic unplug_in,
	// device side
	input wire logic probe_in,
	output logic [1:0] term_sense_out,
	output logic [1:0] rx_signal_out,
	output logic link_break_out
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [1:0] term_ff;

	// far-end load is only meaningful while probed; else a wrong level
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			term_ff <= 2'h0;
		end
		else
		begin
			term_ff <= probe_in ? present_in : ~present_in;
		end
	end

	// line activity and disconnect follow the bench commands
	assign term_sense_out = term_ff;
	assign rx_signal_out = active_in;
	assign link_break_out = unplug_in;
endmodule // rlpm_link_partner

// ===== dv/rlpm_top_tb.sv
module rlpm_top_tb import rlpm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int RETRY = 50;
	localparam int U2_CYC = 3000;

	logic clk, rst, sleep_ctrl, comply, unplug, probe, core_on, brk;
	logic rd, wr, wreq;
	rlpm_pins_t pins;
	logic [1:0] present, active, sense, rx_sig;
	logic [1:0] rx_lowz, tx_lowz, tx_en, tx_eidle, ch_lp;
	rlpm_state_t mode;
	rlpm_cond_t cond;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, d;
	int err_count = 0;
	int tests_run = 0;
	int n;

	// --------------------------------------------------------
	// instances
	// --------------------------------------------------------
	rlpm_top #(.RETRY_CYC(RETRY)) i_rlpm_top (
		.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .SLEEP_CTRL_IN(sleep_ctrl),
		.COMPLIANCE_SELECT_IN(comply), .SETTING_PINS_IN(pins),
		.RX_TERM_SENSE_IN(sense), .RX_SIGNAL_IN(rx_sig),
		.LINK_BREAK_IN(brk), .RX_TERM_LOWZ_OUT(rx_lowz),
		.TX_TERM_LOWZ_OUT(tx_lowz), .TX_ENABLE_OUT(tx_en),
		.TX_EIDLE_OUT(tx_eidle), .CH_LOWPOWER_OUT(ch_lp),
		.RX_DETECT_PROBE_OUT(probe), .CORE_ON_OUT(core_on),
		.MODE_OUT(mode), .COND_OUT(cond), .AVS_ADDRESS_IN(addr),
		.AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
		.AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq));

	rlpm_link_partner i_rlpm_link_partner (
		.clk_in(clk), .rst_in(rst), .present_in(present),
		.active_in(active), .unplug_in(unplug), .probe_in(probe),
		.term_sense_out(sense), .rx_signal_out(rx_sig),
		.link_break_out(brk));

	// --------------------------------------------------------
	// shared tasks
	// --------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask

	task automatic wait_mode(input rlpm_state_t m, input int lim,
		output int cnt);
		cnt = 0;
		@(negedge clk);
		while (mode !== m && cnt < lim)
		begin
			@(negedge clk);
			cnt++;
		end
		chk("mode", 32'(m), 32'(mode));
	endtask

	// one avalon access, held until waitrequest is sampled low
	task automatic bus(input logic we, input logic [3:0] a,
		input logic [31:0] wd, output logic [31:0] rdv);
		int k;
		@(posedge clk);
		addr <= a;
		wdata <= wd;
		rd <= ~we;
		wr <= we;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (wreq !== 1'b0 && k < 50);
		rdv = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (k >= 50)
			chk("waitrequest", 32'h0, 32'h1);
	endtask

	function automatic rlpm_tri_t tp(input int c);
		return (c == 0) ? 2'h1 : (c == 2) ? 2'h2 : 2'h0;
	endfunction

	task automatic wrap_up();
		if (err_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// --------------------------------------------------------
	// scenarios
	// --------------------------------------------------------
	task automatic t_reset();
		comply <= 1'b1;
		repeat (5) @(negedge clk);
		chk("mode", 32'(RLPM_SLEEP), 32'(mode));
		chk("lowz", 32'h0,
			32'({rx_lowz, tx_lowz, tx_en, probe, core_on}));
		@(posedge clk);
		comply <= 1'b0;
		bus(1'b0, 4'h0, 32'h0, d);
		chk("ctrl", 32'h1, d);
		bus(1'b0, 4'hc, 32'h0, d);
		chk("unmapped", 32'h0, d);
		bus(1'b1, 4'h4, 32'hffff_ffff, d);
		bus(1'b0, 4'h4, 32'h0, d);
		chk("status", 32'h0, {29'h0, d[2:0]});
	endtask

	task automatic t_detect();
		sleep_ctrl <= 1'b1;
		wait_mode(RLPM_SETTLE, 1000, n);
		chk("settle", 32'h0, 32'({rx_lowz, probe}));
		wait_mode(RLPM_PROBE, 50, n);
		chk("probe", 32'h1, 32'({rx_lowz, probe}));
		wait_mode(RLPM_RETRY, 100, n);
		chk("retry", 32'h2, 32'({tx_en, ch_lp}));
		wait_mode(RLPM_SETTLE, RETRY + 10, n);
		chk("interval", 32'h1, 32'(n >= RETRY - 2));
		present <= 2'h3;
		wait_mode(RLPM_NORMAL, 100, n);
		chk("normal", 32'hff,
			32'({rx_lowz, tx_lowz, tx_en, 1'b1, core_on}));
	endtask

	task automatic t_eidle();
		@(posedge clk);
		active <= 2'h1;
		@(posedge clk);
		@(negedge clk);
		chk("eidle", 32'h2, 32'(tx_eidle));
		@(posedge clk);
		active <= 2'h3;
		@(posedge clk);
		@(negedge clk);
		chk("eidle", 32'h0, 32'(tx_eidle));
	endtask

	task automatic t_lowpwr();
		bus(1'b1, 4'h0, 32'h0, d);
		active <= 2'h0;
		repeat (U2_CYC + 100) @(negedge clk);
		chk("mode", 32'(RLPM_NORMAL), 32'(mode));
		bus(1'b1, 4'h0, 32'h1, d);
		wait_mode(RLPM_LOWPWR, U2_CYC + 10, n);
		bus(1'b0, 4'h4, 32'h0, d);
		chk("status", 32'(RLPM_LOWPWR), {29'h0, d[2:0]});
		@(posedge clk);
		active <= 2'h1;
		wait_mode(RLPM_NORMAL, 2, n);
		@(posedge clk);
		active <= 2'h3;
	endtask

	task automatic t_break();
		unplug <= 1'b1;
		wait_mode(RLPM_SETTLE, 20, n);
		chk("rx_lowz", 32'h0, 32'(rx_lowz));
		@(posedge clk);
		unplug <= 1'b0;
		wait_mode(RLPM_NORMAL, 100, n);
	endtask

	task automatic t_comply();
		comply <= 1'b1;
		wait_mode(RLPM_COMPLY, 20, n);
		chk("comply", 32'h6, 32'({rx_lowz, probe}));
		@(posedge clk);
		sleep_ctrl <= 1'b0;
		wait_mode(RLPM_SLEEP, 20, n);
		chk("sleep", 32'h0, 32'({rx_lowz, tx_lowz, tx_en}));
		@(posedge clk);
		comply <= 1'b0;
	endtask

	task automatic t_pins();
		rlpm_pins_t p;
		rlpm_cond_t e;
		int a, b, c;
		for (int k = 0; k < 3; k++)
		begin
			a = k;
			b = (k + 1) % 3;
			c = (k + 2) % 3;
			p = {tp(b), tp(a), tp(c), tp(b), tp(a), tp(c)};
			e = {2'(b), 2'(a), 2'(c), 2'(a), 2'(b), 2'(c), 2'(a), 2'(c)};
			@(posedge clk);
			pins <= p;
			repeat (3) @(negedge clk);
			chk("cond", 32'(e), 32'(cond));
			bus(1'b0, 4'h8, 32'h0, d);
			chk("cond_reg", 32'(e), {16'h0, d[15:0]});
		end
	endtask

	// --------------------------------------------------------
	// clock, watchdog and main sequence
	// --------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	initial
	begin
		#(30000 * 100);
		err_count++;
		wrap_up();
	end

	initial
	begin
		rst = 1'b1;
		sleep_ctrl = 1'b0;
		comply = 1'b0;
		pins = '0;
		present = 2'h1;
		active = 2'h3;
		unplug = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 4'h0;
		wdata = 32'h0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_detect();
		t_eidle();
		t_lowpwr();
		t_break();
		t_pins();
		t_comply();
		wrap_up();
	end
endmodule // rlpm_top_tb
